// file: vbf_rx.v
// receive parser for the protected independent-data-line packet format
// assumes a slicer delivers bytes 4..45 of each line, one byte per valid cycle
`timescale 1ns/100ps
`include "vbf_consts.vh"

module vbf_rx (
  input  wire        clk,
  input  wire        rstn,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // slicer side
  input  wire        rx_sop,
  input  wire        rx_valid,
  input  wire [7:0]  rx_byte,
  // application sink side
  output reg         sink_valid,
  output reg  [7:0]  sink_data,
  output reg  [3:0]  sink_row,
  output reg  [5:0]  sink_col,
  output reg         pkt_done,
  output reg         pkt_good,
  output reg         pkt_fec_fail
);

  // ==========================================================
  // hamming 8/4 decode
  // ==========================================================
  // customary table: p1 d1 p2 d2 p3 d3 p4 d4 from bit 0 upward, odd parity [R23]
  function [4:0] ham_dec;
    input [7:0] b;
    reg a_ok;
    reg b_ok;
    reg c_ok;
    reg d_ok;
    reg [3:0] d;
    begin
      a_ok = b[0] ^ b[1] ^ b[5] ^ b[7];
      b_ok = b[1] ^ b[2] ^ b[3] ^ b[7];
      c_ok = b[1] ^ b[3] ^ b[4] ^ b[5];
      d_ok = ^b;
      d = {b[7], b[5], b[3], b[1]};
      if (!d_ok) begin
        // single error: flip the data bit named by the failed checks
        if (!a_ok && !b_ok && !c_ok)
          d[0] = ~d[0];
        else if (a_ok && !b_ok && !c_ok)
          d[1] = ~d[1];
        else if (!a_ok && b_ok && !c_ok)
          d[2] = ~d[2];
        else if (!a_ok && !b_ok && c_ok)
          d[3] = ~d[3];
        ham_dec = {1'b0, d};
      end else begin
        // parity fine but a check fails: double error, not correctable
        ham_dec = {~(a_ok & b_ok & c_ok), d};
      end
    end
  endfunction

  // multiply by the primitive element: one feedback shift [R19]
  function [7:0] gf_mul2;
    input [7:0] v;
    begin
      gf_mul2 = {v[6:0], 1'b0} ^ (v[7] ? `VBF_GF_POLY : 8'h00);
    end
  endfunction

  // ==========================================================
  // register file
  // ==========================================================
  reg  [31:0] ctrl_r;
  reg  [8:4]  sticky_r;
  reg  [3:0]  last_idx_r;
  reg         idx_seen_r;
  reg  [15:0] good_cnt_r;
  reg  [15:0] loss_cnt_r;
  reg         ack_r;

  wire        req     = avs_read | avs_write;
  wire        wr_take = avs_write & ack_r;
  // one wait state on every access so read data comes from a flop
  assign avs_waitrequest = req & ~ack_r;

  wire        cfg_en  = ctrl_r[`VBF_CTRL_EN];
  wire [3:0]  cfg_ch  = ctrl_r[`VBF_CTRL_CHAN_LO +: 4];
  wire [3:0]  cfg_app = ctrl_r[`VBF_CTRL_APP_LO +: 4];
  wire [1:0]  cfg_sub = ctrl_r[`VBF_CTRL_SUB_LO +: 2];

  // ==========================================================
  // packet walker
  // ==========================================================
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_HDR  = 4'b0010;
  localparam [3:0] ST_BODY = 4'b0100;
  localparam [3:0] ST_DROP = 4'b1000;

  reg  [3:0]  state_r;
  reg  [5:0]  pos_r;
  reg         match_r;
  reg         ham_bad_r;
  reg  [7:0]  x_r;
  reg  [7:0]  y_r;
  reg  [3:0]  row_r;

  // a start always restarts the walk, whatever state we are in
  wire [5:0]  pos_cur = rx_sop ? `VBF_POS_CHAN : pos_r;
  wire [4:0]  hd      = ham_dec(rx_byte);
  wire [7:0]  x_nxt   = x_r ^ rx_byte;
  // horner form gives byte i the weight a^(36-i) over 37 bytes [R20]
  wire [7:0]  y_nxt   = gf_mul2(y_r) ^ rx_byte;
  wire        in_pkt  = rx_valid & (rx_sop | ~state_r[0]);
  wire [3:0]  idx_inc = last_idx_r + 4'h1;

  // header byte checks
  wire        fmt_other = hd[0] == 1'b0;                          // [R5]
  wire        fmt_rsvd  = hd[0] & hd[1];                          // [R5]
  wire        fmt_mine  = hd[0] & ~hd[1];                         // [R4] [R5]
  reg         hdr_ok;

  always @* begin
    hdr_ok = ~hd[4];
    case (pos_cur)
      `VBF_POS_CHAN:  hdr_ok = hdr_ok & (hd[3:0] == cfg_ch);                  // [R3] [R24]
      `VBF_POS_DESIG: hdr_ok = hdr_ok & (hd[3:0] == `VBF_DESIG_CODE);         // [R3]
      `VBF_POS_FMT:   hdr_ok = hdr_ok & fmt_mine & (hd[3:2] == cfg_sub);      // [R6] [R24]
      `VBF_POS_APP:   hdr_ok = hdr_ok & (hd[3:0] == cfg_app);                 // [R7] [R24]
      default:        hdr_ok = hdr_ok;
    endcase
  end

  wire        last_hdr  = pos_cur == `VBF_POS_IDX;
  wire        body_byte = state_r[2] & rx_valid & ~rx_sop;
  wire        pkt_end   = body_byte & (pos_r == `VBF_POS_SUF1);
  wire        fec_ok    = (x_nxt == 8'h00) & (y_nxt == 8'h00);   // [R13] [R12]
  // index step check: repeat keeps it, one step advances, else loss [R8] [R9] [R10]
  wire        idx_rep   = idx_seen_r & (row_r == last_idx_r);
  wire        idx_gap   = idx_seen_r & (row_r != last_idx_r) & (row_r != idx_inc);
  wire        good_ev   = pkt_end & fec_ok & ~idx_rep;
  wire        gap_ev    = pkt_end & fec_ok & idx_gap;
  // a start cuts any frame in progress, so its header still gets flagged
  wire        hdr_phase = in_pkt & (rx_sop | state_r[1]);
  wire        ham_ev    = hdr_phase & (pos_cur <= `VBF_POS_IDX) & hd[4];
  wire        rsvd_ev   = hdr_phase & (pos_cur == `VBF_POS_FMT) & fmt_rsvd;
  wire        other_ev  = hdr_phase & (pos_cur == `VBF_POS_FMT) & fmt_other & ~hd[4];

  always @(posedge clk) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      pos_r <= 6'd0;
      match_r <= 1'b0;
      ham_bad_r <= 1'b0;
      x_r <= 8'h00;
      y_r <= 8'h00;
      row_r <= 4'h0;
    end else begin
      case (state_r)
        ST_IDLE, ST_HDR, ST_BODY, ST_DROP: begin
          if (in_pkt) begin
            pos_r <= pos_cur + 6'd1;
            if (rx_sop || state_r[1]) begin
              // header bytes 4..8 are all hamming coded [R2] [R1]
              if (!cfg_en || !hdr_ok) begin
                state_r <= ST_DROP;
              end else if (last_hdr) begin
                row_r <= hd[3:0];                                    // [R16]
                x_r <= 8'h00;
                y_r <= 8'h00;
                state_r <= ST_BODY;
              end else begin
                state_r <= ST_HDR;
              end
            end else if (state_r[2]) begin
              // payload and suffix are plain bytes, all feed the syndrome [R2] [R11]
              x_r <= x_nxt;
              y_r <= y_nxt;
              if (pos_r == `VBF_POS_SUF1)
                state_r <= ST_IDLE;
            end else if (state_r[3] && pos_r == `VBF_POS_SUF1) begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      match_r <= 1'b0;
      ham_bad_r <= 1'b0;
    end
  end

  // ==========================================================
  // sink outputs
  // ==========================================================
  always @(posedge clk) begin
    if (!rstn) begin
      sink_valid <= 1'b0;
      sink_data <= 8'h00;
      sink_row <= 4'h0;
      sink_col <= 6'd0;
      pkt_done <= 1'b0;
      pkt_good <= 1'b0;
      pkt_fec_fail <= 1'b0;
    end else begin
      // rows 14 and 15 hold column protection, not bundle data [R14] [R15] [R17]
      sink_valid <= body_byte & (pos_r <= `VBF_POS_DATAN) & (row_r <= `VBF_LAST_DATA_ROW);
      sink_data <= rx_byte;
      sink_row <= row_r;
      sink_col <= pos_r - `VBF_POS_DATA0;
      pkt_done <= pkt_end;
      pkt_good <= good_ev;
      // every row, protection rows too, carries its own suffix pair [R18]
      pkt_fec_fail <= pkt_end & ~fec_ok;
    end
  end

  // ==========================================================
  // status, counters and bus
  // ==========================================================
  wire [8:4] set_vec  = {other_ev, rsvd_ev, pkt_end & ~fec_ok, ham_ev, gap_ev};
  wire [8:4] clr_vec  = (wr_take && avs_address == `VBF_REG_STATUS) ?
                        avs_writedata[8:4] : 5'b00000;

  always @(posedge clk) begin
    if (!rstn) begin
      ctrl_r <= `VBF_CTRL_RESET;
      sticky_r <= 5'b00000;
      last_idx_r <= 4'h0;
      idx_seen_r <= 1'b0;
      good_cnt_r <= 16'h0000;
      loss_cnt_r <= 16'h0000;
      ack_r <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (wr_take && avs_address == `VBF_REG_CTRL)
        ctrl_r <= avs_writedata;
      // a fresh event beats a write-one clear in the same cycle
      sticky_r <= (sticky_r & ~clr_vec) | set_vec;
      if (pkt_end && fec_ok) begin
        last_idx_r <= row_r;                                         // [R10]
        idx_seen_r <= 1'b1;
      end
      if (good_ev)
        good_cnt_r <= good_cnt_r + 16'h0001;
      if (gap_ev)
        loss_cnt_r <= loss_cnt_r + 16'h0001;                         // [R10]
      if (wr_take && avs_address == `VBF_REG_GOOD_CNT)
        good_cnt_r <= 16'h0000;
      if (wr_take && avs_address == `VBF_REG_LOSS_CNT)
        loss_cnt_r <= 16'h0000;
      if (avs_read && !ack_r) begin
        case (avs_address)
          `VBF_REG_CTRL:     avs_readdata <= ctrl_r;
          `VBF_REG_STATUS:   avs_readdata <= {23'h000000, sticky_r, last_idx_r};
          `VBF_REG_GOOD_CNT: avs_readdata <= {16'h0000, good_cnt_r};
          `VBF_REG_LOSS_CNT: avs_readdata <= {16'h0000, loss_cnt_r};
          default:           avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// file: vbf_consts.vh
// constants for the data-line packet receiver: register map, fields, packet layout
// assumes bytes arrive already assembled, first received bit in bit 0
//
// How it works
// R1: fields in order, least significant bit first
// R2: header through sequence byte Hamming protected
// R3: byte 4 channel, byte 5 all ones
// R4: format byte 6, bit1 one, bit2 zero
// R5: classify format nibble, reject reserved code
// R6: format bits 4,3 are service subselector
// R7: byte 7 four-bit application identifier
// R8: sender increments index modulo sixteen
// R9: repeats keep the same index
// R10: index gap means lost packets
// R11: bytes 9 to 43 plain payload
// R12: bytes 44, 45 carry suffix checks
// R13: two-check single-symbol Reed-Solomon per packet
// R14: 490-byte bundle over 16-packet block
// R15: block is 16 rows by 37 columns
// R16: sequence index equals row in block
// R17: rows 14, 15 vertical column protection
// R18: every row carries horizontal suffix bytes
// R19: multiply by 0x02 with polynomial 0x11D
// R20: X plain xor, Y weighted sum
// R21: first suffix (X^Y)/3, second first^X
// R22: X equals Y gives zero first suffix
// R23: customary Hamming 8/4 code table
// R24: accept only matching configured service
`ifndef VBF_CONSTS_VH
`define VBF_CONSTS_VH

// register byte addresses
`define VBF_REG_CTRL       4'h0
`define VBF_REG_STATUS     4'h4
`define VBF_REG_GOOD_CNT   4'h8
`define VBF_REG_LOSS_CNT   4'hC

// control field positions
`define VBF_CTRL_EN        0
`define VBF_CTRL_CHAN_LO   4
`define VBF_CTRL_APP_LO    8
`define VBF_CTRL_SUB_LO    12
`define VBF_CTRL_RESET     32'h0000_0000

// status field positions
`define VBF_ST_IDX_LO      0
`define VBF_ST_GAP         4
`define VBF_ST_HAM_ERR     5
`define VBF_ST_FEC_ERR     6
`define VBF_ST_RSVD_FMT    7
`define VBF_ST_OTHER_FMT   8

// packet layout (byte numbers on the line)
`define VBF_POS_CHAN       6'd4
`define VBF_POS_DESIG      6'd5
`define VBF_POS_FMT        6'd6
`define VBF_POS_APP        6'd7
`define VBF_POS_IDX        6'd8
`define VBF_POS_DATA0      6'd9
`define VBF_POS_DATAN      6'd43
`define VBF_POS_SUF1       6'd45
`define VBF_DESIG_CODE     4'hF
`define VBF_LAST_DATA_ROW  4'hD
`define VBF_GF_POLY        8'h1D

`endif

// file: vbf_rx_chk.sv
// port assertions for the data-line packet receiver
// assumes one clock and rstn, synchronous and active low
`timescale 1ns/100ps
module vbf_rx_chk (
  input logic       clk,
  input logic       rstn,
  input logic       avs_read,
  input logic       avs_write,
  input logic       avs_waitrequest,
  input logic       rx_sop,
  input logic       rx_valid,
  input logic       sink_valid,
  input logic [3:0] sink_row,
  input logic [5:0] sink_col,
  input logic       pkt_done,
  input logic       pkt_good,
  input logic       pkt_fec_fail
);
  // ====================
  // sequences
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire req = avs_read || avs_write;
  sequence s_acc;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  // header bytes 4..8 can yield neither payload nor a verdict
  sequence s_hdr;
    (!sink_valid && !pkt_done) [*5];
  endsequence
  // ====================
  // assertions
  chk_bus_wait: assert property ($rose(req) |-> s_acc)
    else $error("access not one wait state");
  chk_bus_idle: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without request");
  chk_hdr_quiet: assert property (rx_sop && rx_valid |=> s_hdr)
    else $error("output during header");
  chk_sink_cause: assert property (sink_valid |-> $past(rx_valid))
    else $error("payload without byte");
  chk_sink_range: assert property (sink_valid |-> sink_row <= 4'hD && sink_col <= 6'h22)
    else $error("payload row or column out of range");
  chk_done_cause: assert property (pkt_done |-> $past(rx_valid))
    else $error("verdict without suffix byte");
  chk_done_pulse: assert property (pkt_done |=> !pkt_done)
    else $error("verdict longer than one cycle");
  chk_good_only: assert property (pkt_good |-> pkt_done && !pkt_fec_fail)
    else $error("good without clean verdict");
  chk_fail_done: assert property (pkt_fec_fail |-> pkt_done)
    else $error("check failure without verdict");
endmodule

bind vbf_rx vbf_rx_chk u_chk (.clk(clk), .rstn(rstn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .rx_sop(rx_sop),
  .rx_valid(rx_valid), .sink_valid(sink_valid), .sink_row(sink_row), .sink_col(sink_col),
  .pkt_done(pkt_done), .pkt_good(pkt_good), .pkt_fec_fail(pkt_fec_fail));

// file: vbf_slicer_model.sv
// slicer stand-in: frames line bytes 4..45 onto the receiver byte port
// assumes one byte per clock, with one idle hole mid-payload
`timescale 1ns/100ps
module vbf_slicer_model (
  output logic       rx_sop,
  output logic       rx_valid,
  output logic [7:0] rx_byte,
  input  logic       clk
);
  initial begin
    rx_sop = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // ====================
  // field coding
  function automatic logic [7:0] ham(input logic [3:0] d);
    logic p1, p2, p3;
    p1 = ~(d[0] ^ d[2] ^ d[3]);
    p2 = ~(d[0] ^ d[1] ^ d[3]);
    p3 = ~(d[0] ^ d[1] ^ d[2]);
    return {d[3], ~(p1 ^ p2 ^ p3 ^ (^d)), d[2], p3, d[1], p2, d[0], p1};
  endfunction
  function automatic logic [7:0] xt(input logic [7:0] v);
    return {v[6:0], 1'b0} ^ (v[7] ? 8'h1D : 8'h00);
  endfunction
  // ====================
  // framing; fl is xored into byte at after coding, to inject faults
  task automatic send(input logic [3:0] ch, fm, ap, ix, input logic [7:0] base, fl,
                      input int at);
    logic [7:0] b [42];
    logic [7:0] x, y, s;
    x = 8'h00;
    y = 8'h00;
    s = 8'h00;
    b[0] = ham(ch);
    b[1] = ham(4'hF);
    b[2] = ham(fm);
    b[3] = ham(ap);
    b[4] = ham(ix);
    for (int i = 0; i < 35; i++) begin
      b[5 + i] = base + 8'(i * 7);
      x ^= b[5 + i];
      y = xt(y) ^ b[5 + i];
    end
    y = xt(xt(y));
    // brute-force division by 3; x == y lands on zero by itself
    for (int v = 0; v < 256; v++)
      if ((8'(v) ^ xt(8'(v))) == (x ^ y)) s = 8'(v);
    b[40] = s;
    b[41] = s ^ x;
    b[at] ^= fl;
    for (int k = 0; k < 42; k++) begin
      @(posedge clk);
      if (k == 20) begin
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
        @(posedge clk);
      end
      rx_sop <= (k == 0);
      rx_valid <= 1'b1;
      rx_byte <= b[k];
    end
    @(posedge clk);
    rx_sop <= 1'b0;
    rx_valid <= 1'b0;
    rx_byte <= ~b[41];
  endtask
endmodule

// file: testbench.sv
// self-checking bench for the data-line packet receiver
// assumes the slicer stand-in and the bound checker are compiled first
`timescale 1ns/100ps
module testbench;
  logic        clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic        rx_sop, rx_valid, sink_valid, pkt_done, pkt_good, pkt_fec_fail;
  logic [3:0]  avs_address, sink_row, erow;
  logic [5:0]  sink_col;
  logic [7:0]  rx_byte, sink_data, ebase;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int          errors, checks, nb, nd, ng, nf;

  vbf_rx dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_sop(rx_sop), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .sink_valid(sink_valid), .sink_data(sink_data),
    .sink_row(sink_row), .sink_col(sink_col), .pkt_done(pkt_done),
    .pkt_good(pkt_good), .pkt_fec_fail(pkt_fec_fail));
  vbf_slicer_model slicer (.rx_sop(rx_sop), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .clk(clk));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ====================
  // tasks
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    logic ws;
    logic [31:0] rv;
    n = 0;
    ws = 1'b1;
    rv = 32'h0000_0000;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // sample between edges what the next rising edge will see
    do begin
      @(negedge clk);
      ws = avs_waitrequest;
      rv = avs_readdata;
      @(posedge clk);
      n++;
    end while (ws !== 1'b0 && n < 50);
    if (ws !== 1'b0) begin
      errors++;
      report_and_stop;
    end
    rd = rv;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e, input string w);
    bus(1'b0, a, 32'h0000_0000);
    check(w, rd, e);
  endtask
  // sends one line on channel 3 and counts what the receiver gives back
  task automatic pkt(input logic [3:0] fm, ap, ix, input logic [7:0] fl, input int at,
                     input int eb, ed, eg, ef);
    nb = 0;
    nd = 0;
    ng = 0;
    nf = 0;
    erow = ix;
    ebase = {ix, 4'h1};
    slicer.send(4'h3, fm, ap, ix, ebase, fl, at);
    repeat (3) @(posedge clk);
    check("payload bytes", nb, eb);
    check("done pulses", nd, ed);
    check("good pulses", ng, eg);
    check("fail pulses", nf, ef);
  endtask
  always @(posedge clk) begin
    if (sink_valid === 1'b1) begin
      nb++;
      check("sink data", sink_data, 8'(ebase + 8'(sink_col) * 8'h07));
      check("sink row", sink_row, erow);
    end
    if (pkt_done === 1'b1) nd++;
    if (pkt_good === 1'b1) ng++;
    if (pkt_fec_fail === 1'b1) nf++;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop;
  end
  // ====================
  // sequence
  initial begin
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    errors = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) rchk(i == 4 ? 4'h2 : 4'(i * 4), 32'h0, "reset word");
    pkt(4'h9, 4'h5, 4'h0, 8'h00, 0, 0, 0, 0, 0);
    bus(1'b1, 4'h0, 32'h0000_2531);
    pkt(4'h9, 4'h5, 4'h0, 8'h00, 0, 35, 1, 1, 0);
    pkt(4'h9, 4'h5, 4'h1, 8'h04, 3, 35, 1, 1, 0);
    pkt(4'h9, 4'h5, 4'h1, 8'h00, 0, 35, 1, 0, 0);
    pkt(4'h9, 4'h5, 4'h3, 8'h00, 0, 35, 1, 1, 0);
    rchk(4'h4, 32'h0000_0013, "status");
    rchk(4'hC, 32'h0000_0001, "gap count");
    rchk(4'h8, 32'h0000_0003, "good count");
    pkt(4'h9, 4'h5, 4'h4, 8'h01, 41, 35, 1, 0, 1);
    pkt(4'h9, 4'h5, 4'hE, 8'h00, 0, 0, 1, 1, 0);
    pkt(4'hB, 4'h5, 4'hF, 8'h00, 0, 0, 0, 0, 0);
    pkt(4'h8, 4'h5, 4'hF, 8'h00, 0, 0, 0, 0, 0);
    pkt(4'h9, 4'h6, 4'hF, 8'h00, 0, 0, 0, 0, 0);
    pkt(4'hD, 4'h5, 4'hF, 8'h00, 0, 0, 0, 0, 0);
    pkt(4'h9, 4'h5, 4'hF, 8'h03, 3, 0, 0, 0, 0);
    rchk(4'h4, 32'h0000_01FE, "status flags");
    bus(1'b1, 4'h4, 32'h0000_01F0);
    rchk(4'h4, 32'h0000_000E, "status cleared");
    bus(1'b1, 4'h8, 32'h0000_0000);
    rchk(4'h8, 32'h0000_0000, "good cleared");
    report_and_stop;
  end
endmodule
